/* File: common/tmc_pkg.sv */
// Constants, state types and register map of the 16-bit timer/counter
`default_nettype none
package tmc_pkg;
	// Register byte addresses
	localparam logic [5:0] ADR_FLAGS = 6'h0b;
	localparam logic [5:0] ADR_FORCE = 6'h22;
	localparam logic [5:0] ADR_CAPL  = 6'h24;
	localparam logic [5:0] ADR_CAPH  = 6'h25;
	localparam logic [5:0] ADR_CMPBL = 6'h26;
	localparam logic [5:0] ADR_CMPBH = 6'h27;
	localparam logic [5:0] ADR_CMPAL = 6'h2a;
	localparam logic [5:0] ADR_CMPAH = 6'h2b;
	localparam logic [5:0] ADR_CNTL  = 6'h2c;
	localparam logic [5:0] ADR_CNTH  = 6'h2d;
	localparam logic [5:0] ADR_CTRLB = 6'h2e;
	localparam logic [5:0] ADR_CTRLA = 6'h30;
	// Field positions
	localparam int CB_FILT = 7;
	localparam int CB_EDGE = 6;
	localparam int FRC_A   = 7;
	localparam int FL_CAP  = 5;
	localparam int FL_CMPA = 1;
	localparam int FL_OVF  = 0;
	// Reset values and masks
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [7:0]  CTRLB_WMASK = 8'hdf;
	localparam logic [7:0]  FLAGS_MASK  = 8'h27;
	// Fixed TOP values and MAX
	localparam logic [15:0] TOP_8   = 16'h00ff;
	localparam logic [15:0] TOP_9   = 16'h01ff;
	localparam logic [15:0] TOP_10  = 16'h03ff;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	// Waveform mode codes
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_CTC_A  = 4'h4;
	localparam logic [3:0] WM_PFC_I  = 4'h8;
	localparam logic [3:0] WM_PFC_A  = 4'h9;
	localparam logic [3:0] WM_PC_I   = 4'ha;
	localparam logic [3:0] WM_CTC_I  = 4'hc;
	localparam logic [3:0] WM_RSVD   = 4'hd;
	localparam logic [3:0] WM_FAST_I = 4'he;
	// Capture filter length in samples
	localparam int FILT_LEN = 4;
	typedef enum logic {CNT_UP, CNT_DOWN} tmc_dir_t;
	typedef struct packed {
		logic [7:0]              ctrl_a;
		logic [7:0]              ctrl_b;
		logic [7:0]              flags;
		logic [15:0]             cnt;
		tmc_dir_t                dir;
		logic [1:0][15:0]        ocr;
		logic [1:0][15:0]        obuf;
		logic [15:0]             icr;
		logic [7:0]              temp;
		logic [9:0]              psc;
		logic                    ext_prev;
		logic [FILT_LEN-2:0]     hist;
		logic                    flt;
		logic                    cap_prev;
		logic                    blk;
		logic [1:0]              wout;
		logic [7:0]              rdata;
	} tmc_state_t;
endpackage : tmc_pkg
`default_nettype wire

/* File: logic/tmc_timer16.sv */
// 16-bit timer/counter with modes, capture, compare and byte register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16 import tmc_pkg::*; (
	input  wire logic       clk,           // 20 MHz system clock
	input  wire logic       reset_n,       // Asynchronous reset, active low
	input  wire logic [5:0] addr,          // Register byte address
	input  wire logic [7:0] wdata,         // Write data
	input  wire logic       wr,            // Write strobe
	input  wire logic       rd,            // Read strobe
	output logic      [7:0] rdata,         // Read data, cycle after read
	input  wire logic       capture_pin,   // Capture input
	input  wire logic       ext_count_pin, // External count input
	output logic            wave_out_a,    // Waveform output A
	output logic            wave_out_b,    // Waveform output B
	output logic            wave_en_a,     // Output A drives its pin
	output logic            wave_en_b      // Output B drives its pin
);
	tmc_state_t  s;
	tmc_state_t  next_s;
	logic [3:0]  wgm;
	logic [2:0]  cs;
	logic [15:0] top;
	logic        tick;
	logic        run;
	logic        is_pwm;
	logic        dual;
	logic        icr_top;
	logic        at_top;
	logic        at_bot;
	logic        upd;
	logic        src;
	logic        cap_evt;
	logic [1:0]  frc;
	logic [1:0]  mtch;
	logic [1:0]  en;
	logic [1:0]  act;

	always_comb begin
		next_s = s;
		// Mode field
		// mode decode
		wgm = {s.ctrl_b[4:3], s.ctrl_a[1:0]};
		cs = s.ctrl_b[2:0];
		case (wgm)
			4'h1, 4'h5: top = TOP_8;
			4'h2, 4'h6: top = TOP_9;
			4'h3, 4'h7: top = TOP_10;
			4'h4, 4'h9, 4'hb, 4'hf: top = s.ocr[0];
			4'h8, 4'ha, 4'hc, 4'he: top = s.icr;
			default: top = CNT_MAX;
		endcase
		is_pwm = !(wgm == WM_NORMAL || wgm == WM_CTC_A || wgm == WM_CTC_I);
		dual = (wgm inside {4'h1, 4'h2, 4'h3, WM_PFC_I, WM_PFC_A, WM_PC_I, 4'hb});
		icr_top = (wgm inside {WM_PFC_I, WM_PC_I, WM_CTC_I, WM_FAST_I});
		upd = (wgm == WM_PFC_I || wgm == WM_PFC_A) ? (s.cnt == RST_WORD) : (s.cnt == top);
		next_s.psc = s.psc + 10'h001;
		next_s.ext_prev = ext_count_pin;
		case (cs)
			3'h1: tick = 1'b1;
			3'h2: tick = &s.psc[2:0];
			3'h3: tick = &s.psc[5:0];
			3'h4: tick = &s.psc[7:0];
			3'h5: tick = &s.psc;
			3'h6: tick = s.ext_prev && !ext_count_pin;
			3'h7: tick = !s.ext_prev && ext_count_pin;
			default: tick = 1'b0;
		endcase
		run = tick && (wgm != WM_RSVD);
		at_top = (s.cnt == top);
		at_bot = (s.cnt == RST_WORD);
		next_s.hist = {s.hist[FILT_LEN-3:0], capture_pin};
		if (s.hist == {(FILT_LEN-1){capture_pin}}) begin
			next_s.flt = capture_pin;
		end
		src = s.ctrl_b[CB_FILT] ? s.flt : capture_pin;
		next_s.cap_prev = src;
		cap_evt = !icr_top && (src != s.cap_prev) && (src == s.ctrl_b[CB_EDGE]);
		// Flag clear by writing one
		if (wr && addr == ADR_FLAGS) begin
			next_s.flags = s.flags & ~(wdata & FLAGS_MASK);
		end
		// Counting sequence
		if (run) begin
			next_s.blk = 1'b0;
			if (dual) begin
				if (s.dir == CNT_UP) begin
					if (at_top) begin
						next_s.dir = CNT_DOWN;
						next_s.cnt = s.cnt - 16'h0001;
					end else begin
						next_s.cnt = s.cnt + 16'h0001;
					end
				end else if (at_bot) begin
					next_s.dir = CNT_UP;
					next_s.cnt = s.cnt + 16'h0001;
				end else begin
					next_s.cnt = s.cnt - 16'h0001;
				end
			end else begin
				next_s.dir = CNT_UP;
				if (wgm != WM_NORMAL && at_top) begin
					next_s.cnt = RST_WORD;
				end else begin
					next_s.cnt = s.cnt + 16'h0001;
				end
			end
		end
		for (int i = 0; i < 2; i++) begin
			act = s.ctrl_a[(7 - 2 * i) -: 2];
			mtch[i] = run && (s.cnt == s.ocr[i]) && !s.blk;
			frc[i] = wr && addr == ADR_FORCE && wdata[FRC_A - i] && !is_pwm;
			if (run && is_pwm && upd) begin
				next_s.ocr[i] = s.obuf[i];
			end
			if (!is_pwm) begin
				if (mtch[i] || frc[i]) begin
					case (act)
						2'b01: next_s.wout[i] = !s.wout[i];
						2'b10: next_s.wout[i] = 1'b0;
						2'b11: next_s.wout[i] = 1'b1;
						default: ;
					endcase
				end
			end else begin
				if (mtch[i] && act == 2'b01 && i == 0 && wgm[3]) begin
					next_s.wout[i] = !s.wout[i];
				end else if (mtch[i] && act[1]) begin
					next_s.wout[i] = dual ? (act[0] ^ (s.dir == CNT_DOWN)) : act[0];
				end
				if (!dual && run && at_top && act[1]) begin
					next_s.wout[i] = !act[0];
				end
			end
			en[i] = (act != 2'b00) && !(act == 2'b01 && is_pwm && !(i == 0 && wgm[3]));
		end
		// Register writes
		if (wr) begin
			case (addr)
				ADR_CTRLA: next_s.ctrl_a = wdata;
				ADR_CTRLB: next_s.ctrl_b = wdata & CTRLB_WMASK;
				ADR_CAPH, ADR_CMPAH, ADR_CMPBH, ADR_CNTH: next_s.temp = wdata;
				ADR_CAPL: next_s.icr = {s.temp, wdata};
				ADR_CMPAL: begin
					next_s.obuf[0] = {s.temp, wdata};
					if (!is_pwm) begin
						next_s.ocr[0] = {s.temp, wdata};
					end
				end
				ADR_CMPBL: begin
					next_s.obuf[1] = {s.temp, wdata};
					if (!is_pwm) begin
						next_s.ocr[1] = {s.temp, wdata};
					end
				end
				ADR_CNTL: begin
					next_s.cnt = {s.temp, wdata};
					next_s.blk = 1'b1;
				end
				default: ;
			endcase
		end
		// Register reads
		next_s.rdata = RST_BYTE;
		if (rd) begin
			case (addr)
				ADR_CTRLA: next_s.rdata = s.ctrl_a;
				ADR_CTRLB: next_s.rdata = s.ctrl_b;
				ADR_FLAGS: next_s.rdata = s.flags;
				ADR_CMPAL: next_s.rdata = s.obuf[0][7:0];
				ADR_CMPAH: next_s.rdata = s.obuf[0][15:8];
				ADR_CMPBL: next_s.rdata = s.obuf[1][7:0];
				ADR_CMPBH: next_s.rdata = s.obuf[1][15:8];
				ADR_CNTL: begin
					next_s.rdata = s.cnt[7:0];
					next_s.temp = s.cnt[15:8];
				end
				ADR_CAPL: begin
					next_s.rdata = s.icr[7:0];
					next_s.temp = s.icr[15:8];
				end
				ADR_CNTH, ADR_CAPH: next_s.rdata = s.temp;
				default: next_s.rdata = RST_BYTE;
			endcase
		end
		if (cap_evt) begin
			next_s.icr = s.cnt;
			next_s.flags[FL_CAP] = 1'b1;
		end
		if (run && icr_top && at_top) begin
			next_s.flags[FL_CAP] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			if (mtch[i]) begin
				next_s.flags[FL_CMPA + i] = 1'b1;
			end
		end
		if (run && (dual ? at_bot : (wgm inside {4'h5, 4'h6, 4'h7, WM_FAST_I, 4'hf}) ?
				at_top : (s.cnt == CNT_MAX))) begin
			next_s.flags[FL_OVF] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign wave_out_a = s.wout[0];
	assign wave_out_b = s.wout[1];
	assign wave_en_a = en[0];
	assign wave_en_b = en[1];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_norm_ovf;
		run && wgm == WM_NORMAL && s.cnt == CNT_MAX |=> s.flags[FL_OVF] && s.cnt == RST_WORD;
	endproperty
	a_norm_ovf: assert property (p_norm_ovf) else $error("normal overflow missed");
	property p_force_rd;
		rd && addr == ADR_FORCE |=> rdata == RST_BYTE;
	endproperty
	a_force_rd: assert property (p_force_rd) else $error("force reg read nonzero");
	property p_capture;
		cap_evt |=> s.icr == $past(s.cnt) && s.flags[FL_CAP];
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost");
	property p_cap_off;
		icr_top |-> !cap_evt;
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("capture while TOP");
	property p_edge;
		cap_evt |-> src == s.ctrl_b[CB_EDGE] && $past(src) != src;
	endproperty
	a_edge: assert property (p_edge) else $error("wrong capture edge");
	property p_blk;
		wr && addr == ADR_CNTL |=> !mtch[0] && !mtch[1];
	endproperty
	a_blk: assert property (p_blk) else $error("match after counter write");
	property p_cmp_wr;
		wr && addr == ADR_CMPAL && !is_pwm |=> s.ocr[0] == {$past(s.temp), $past(wdata)};
	endproperty
	a_cmp_wr: assert property (p_cmp_wr) else $error("compare write wrong");
	property p_stop;
		cs == 3'h0 && !wr ##1 !$past(wr) |-> s.cnt == $past(s.cnt);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped counter moved");
	property p_filt;
		s.ctrl_b[CB_FILT] && $rose(s.flt) |-> $past(capture_pin, 1) && $past(capture_pin, 2)
			&& $past(capture_pin, 3) && $past(capture_pin, 4);
	endproperty
	a_filt: assert property (p_filt) else $error("filter changed early");
	property p_force;
		frc[0] && !mtch[0] && s.ctrl_a[7:6] == 2'b01 |=> s.wout[0] != $past(s.wout[0])
			&& s.flags[FL_CMPA] == $past(s.flags[FL_CMPA]);
	endproperty
	a_force: assert property (p_force) else $error("forced toggle wrong");
	c_capture: cover property (cap_evt);
	c_pc_turn: cover property (run && dual && at_top ##[1:300] run && at_bot);
	c_force: cover property (frc[1]);
	c_ctc_wrap: cover property (run && wgm == WM_CTC_A && at_top);
endmodule : tmc_timer16
`default_nettype wire

/* File: test/tb_tmc_timer16.sv */
// Self-checking testbench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_tmc_timer16 import tmc_pkg::*;;
	logic       clk;
	logic       reset_n;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       capture_pin;
	logic       ext_count_pin;
	logic       wave_out_a;
	logic       wave_out_b;
	logic       wave_en_a;
	logic       wave_en_b;
	int         num_errors;
	int         checks_done;
	logic [15:0] v;

	tmc_timer16 u_tmc_timer16 (
		.clk           (clk),
		.reset_n       (reset_n),
		.addr          (addr),
		.wdata         (wdata),
		.wr            (wr),
		.rd            (rd),
		.rdata         (rdata),
		.capture_pin   (capture_pin),
		.ext_count_pin (ext_count_pin),
		.wave_out_a    (wave_out_a),
		.wave_out_b    (wave_out_b),
		.wave_en_a     (wave_en_a),
		.wave_en_b     (wave_en_b)
	);

	always #25 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
		wr_reg(lo + 6'h01, d[15:8]);
		wr_reg(lo, d[7:0]);
	endtask : wr16

	task automatic rd16(input logic [5:0] lo, output logic [15:0] d);
		rd_reg(lo, d[7:0]);
		rd_reg(lo + 6'h01, d[15:8]);
	endtask : rd16

	task automatic t_reset;
		rd_reg(ADR_CTRLB, v[7:0]);
		chk(v[7:0], 8'h00, "ctrl b reset");
		rd16(ADR_CMPAL, v);
		chk(v, 16'h0000, "compare a reset");
		chk({wave_en_a, wave_en_b}, 2'h0, "outputs disconnected");
		wr_reg(ADR_CTRLB, 8'hdf);
		rd_reg(ADR_CTRLB, v[7:0]);
		chk(v[7:0], 8'hdf, "ctrl b readback");
		wr_reg(ADR_CTRLB, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_access;
		wr16(ADR_CNTL, 16'h01ff);
		rd16(ADR_CNTL, v);
		chk(v, 16'h01ff, "counter word");
		wr16(ADR_CMPAL, 16'h1234);
		wr_reg(ADR_CNTH, 8'h77);
		rd_reg(ADR_CMPAH, v[7:0]);
		chk(v[7:0], 8'h12, "compare high direct");
		rd16(ADR_CMPAL, v);
		chk(v, 16'h1234, "compare word");
		$display("test access done");
	endtask : t_access

	task automatic t_force;
		logic [1:0] act [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
		logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int ch = 0; ch < 2; ch++) begin
			for (int i = 0; i < 4; i++) begin
				wr_reg(ADR_CTRLA, (ch == 0) ? {act[i], 6'h00} : {2'h0, act[i], 4'h0});
				wr_reg(ADR_FORCE, (ch == 0) ? 8'h80 : 8'h40);
				@(posedge clk);
				#1 chk((ch == 0) ? wave_out_a : wave_out_b, exp[i], "forced level");
				chk((ch == 0) ? wave_en_a : wave_en_b, 1'b1, "output driven");
			end
		end
		rd_reg(ADR_FORCE, v[7:0]);
		chk(v[7:0], 8'h00, "force reads zero");
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0], 8'h00, "force sets no flag");
		wr_reg(ADR_CTRLA, 8'h00);
		$display("test force done");
	endtask : t_force

	task automatic t_count;
		wr16(ADR_CMPAL, 16'h0002);
		wr16(ADR_CNTL, 16'hfffe);
		wr_reg(ADR_CTRLB, 8'h01);
		repeat (8) @(posedge clk);
		wr_reg(ADR_CTRLB, 8'h00);
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0] & 8'h03, 8'h03, "overflow and match");
		wr_reg(ADR_FLAGS, 8'h27);
		wr16(ADR_CNTL, 16'h0000);
		wr_reg(ADR_CTRLB, 8'h07);
		repeat (3) begin
			@(posedge clk) ext_count_pin <= 1'b1;
			repeat (2) @(posedge clk);
			ext_count_pin <= 1'b0;
			repeat (2) @(posedge clk);
		end
		wr_reg(ADR_CTRLB, 8'h06);
		@(posedge clk) ext_count_pin <= 1'b1;
		repeat (2) @(posedge clk);
		ext_count_pin <= 1'b0;
		repeat (3) @(posedge clk);
		wr_reg(ADR_CTRLB, 8'h00);
		rd16(ADR_CNTL, v);
		chk(v, 16'h0004, "external edges");
		$display("test count done");
	endtask : t_count

	task automatic pin_to(input logic lvl, input int n);
		@(posedge clk) capture_pin <= lvl;
		repeat (n) @(posedge clk);
	endtask : pin_to

	task automatic t_capture;
		wr16(ADR_CNTL, 16'h1234);
		wr_reg(ADR_CTRLB, 8'h40);
		wr_reg(ADR_FLAGS, 8'h27);
		pin_to(1'b1, 4);
		rd16(ADR_CAPL, v);
		chk(v, 16'h1234, "rising capture");
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0], 8'h20, "capture flag");
		wr_reg(ADR_FLAGS, 8'h27);
		wr16(ADR_CNTL, 16'h0056);
		wr_reg(ADR_CTRLB, 8'h00);
		pin_to(1'b0, 4);
		rd16(ADR_CAPL, v);
		chk(v, 16'h0056, "falling capture");
		wr_reg(ADR_FLAGS, 8'h27);
		wr_reg(ADR_CTRLB, 8'h18);
		pin_to(1'b1, 4);
		pin_to(1'b0, 4);
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0], 8'h00, "capture off at top");
		wr_reg(ADR_CTRLB, 8'hc0);
		pin_to(1'b1, 2);
		pin_to(1'b0, 6);
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0], 8'h00, "short pulse filtered");
		pin_to(1'b1, 8);
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0], 8'h20, "long pulse passes");
		$display("test capture done");
	endtask : t_capture

	// Fast PWM 8-bit: buffered compare and overflow at TOP
	task automatic t_pwm;
		wr_reg(ADR_CTRLA, 8'h01);
		wr_reg(ADR_CTRLB, 8'h08);
		wr_reg(ADR_FORCE, 8'h00);
		wr_reg(ADR_FLAGS, 8'h27);
		wr16(ADR_CNTL, 16'h00fd);
		wr16(ADR_CMPAL, 16'h0010);
		wr_reg(ADR_CTRLB, 8'h09);
		repeat (4) @(posedge clk);
		wr_reg(ADR_CTRLB, 8'h08);
		rd_reg(ADR_FLAGS, v[7:0]);
		chk(v[7:0] & 8'h03, 8'h01, "overflow at top, old compare gone");
		rd16(ADR_CNTL, v);
		chk(v, 16'h0003, "wrap after top");
		wr_reg(ADR_CTRLA, 8'h00);
		wr_reg(ADR_CTRLB, 8'h00);
		$display("test pwm done");
	endtask : t_pwm

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		addr = 6'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		capture_pin = 1'b0;
		ext_count_pin = 1'b0;
		num_errors = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_access();
		t_force();
		t_count();
		t_capture();
		t_pwm();
		close_out();
	end

	// Watchdog well beyond the expected run
	initial begin
		#400us;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule : tb_tmc_timer16
`default_nettype wire
